//--- inc/fsr_pkg.sv
// constants, status layout and byte-engine states of status register 1
// assumes a single 200 MHz core clock that oversamples the serial pins
package fsr_pkg;

	typedef struct packed {
		logic       status_protect_bit_low;
		logic       protect_granule_select;
		logic       protect_direction_select;
		logic [2:0] protect_range_field;
		logic       write_enable_latch;
		logic       busy_flag;
	} fsr_status_t;

	typedef enum logic [5:0] {
		ST_CMD   = 6'h01,
		ST_SEL   = 6'h02,
		ST_ADDR  = 6'h04,
		ST_WDATA = 6'h08,
		ST_RDATA = 6'h10,
		ST_SKIP  = 6'h20
	} fsr_state_t;

	localparam int          BIT_PROT_LOW = 7;
	localparam int          BIT_SIZE     = 6;
	localparam int          BIT_DIR      = 5;
	localparam int          BIT_RANGE_HI = 4;
	localparam int          BIT_RANGE_LO = 2;
	localparam int          BIT_LATCH    = 1;
	localparam int          BIT_BUSY     = 0;
	localparam logic [7:0]  SR1_RESET    = 8'h00;

	localparam logic [7:0]  CMD_WRSR     = 8'h01;
	localparam logic [7:0]  CMD_PROG     = 8'h02;
	localparam logic [7:0]  CMD_RDSR     = 8'h05;
	localparam logic [7:0]  CMD_WREN     = 8'h06;
	localparam logic [7:0]  CMD_ER4K     = 8'h20;
	localparam logic [7:0]  CMD_VWREN    = 8'h50;
	localparam logic [7:0]  CMD_IRD      = 8'h65;
	localparam logic [7:0]  CMD_IWR      = 8'h71;
	localparam logic [7:0]  CMD_ER64K    = 8'hd8;
	localparam logic [7:0]  SEL_SR1      = 8'h01;

	localparam int          ADDR_W       = 24;
	localparam logic [1:0]  ADDR_LAST    = 2'h2;
	localparam int          SHIFT_64K    = 16;
	localparam int          SHIFT_4K     = 12;

	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          OP_TIME_NS    = 50000;
	localparam int          OP_CYCLES     = (OP_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int          CNT_W         = 16;

endpackage

//--- src/fsr_pin_sync.sv
// two-stage synchroniser for the serial pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module fsr_pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					meta_reg[i] <= 1'b1;
					q[i]        <= 1'b1;
				end else if (ce) begin
					meta_reg[i] <= d[i];
					q[i]        <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule

//--- src/fsr_status_one.sv
// status register 1 of a serial flash with its command byte engine
// assumes spi mode 0 pins, sck well below a quarter of clk
//
// What this block does
// - bit 7 is a writable protect bit that with the wp pin locks status writes.
// - bit 6 is writable and picks 64 kB granules at 0 and 4 kB granules at 1.
// - bit 5 is writable and grows protection from the bottom at 0, top at 1.
// - bits 4:2 are a writable range field, zero at power-up meaning no protection.
// - program and erase aimed at the protected region are refused.
// - bit 1 mirrors the write enable latch; while clear, writes are ignored except a status write right after 50h.
// - the write enable latch clears at power-up and at reset.
// - an incomplete or unknown command leaves a set latch alone.
// - an abort clears the latch only after a whole write-type command.
// - the 06h command sets the latch and the 50h command does not.
// - bit 0 reads 1 while an internal operation runs and 0 when ready.
// - a status read refreshes the byte it shifts out on every byte.
// - status register 1 is read with 05h and written with 01h.
// - 65h and 71h followed by select byte 01h read or write the register.
// - a write after 50h updates only flops, after 06h also the slow copy.
`timescale 1ns/1ps
module fsr_status_one #(
	parameter int OP_CYCLES = fsr_pkg::OP_CYCLES
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	input  wire logic          dev_rst,
	input  wire logic          sck,
	input  wire logic          cs_n,
	input  wire logic          si,
	input  wire logic          wp_n,
	output logic               so_out,
	output logic               so_oe,
	output fsr_pkg::fsr_status_t sr1_reg
);
	logic [3:0]               sync_q;
	logic                     sck_s, cs_s, si_s, wp_s;
	logic                     sck_d_reg, cs_d_reg;
	fsr_pkg::fsr_state_t      state_reg;
	logic [2:0]               bit_reg;
	logic [7:0]               in_reg, cmd_reg, wdata_reg, out_reg;
	logic [7:0]               nv_reg, nv_pend_reg;
	logic [fsr_pkg::ADDR_W-1:0] addr_reg;
	logic [1:0]               acnt_reg;
	logic                     full_reg, vwe_reg, nv_busy_reg;
	logic [fsr_pkg::CNT_W-1:0] cnt_reg;
	logic                     sck_rise, sck_fall, cs_rise, sel, byte_end;
	logic [7:0]               shift_in;
	logic                     go, wren_go, vwren_go, wr_go, mem_go;
	logic                     locked, prot, wr_vol, wr_nv, mem_ok, op_done;
	logic                     enter_rd, wel_next, busy_next;

	fsr_pin_sync #(.W(4)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.d       ({wp_n, si, cs_n, sck}),
		.q       (sync_q)
	);
	assign sck_s = sync_q[0];
	assign cs_s  = sync_q[1];
	assign si_s  = sync_q[2];
	assign wp_s  = sync_q[3];

	function automatic logic prot_hit(
		input logic [fsr_pkg::ADDR_W-1:0] a,
		input fsr_pkg::fsr_status_t       s
	);
		logic [fsr_pkg::ADDR_W-1:0] off, gran, lim;
		off  = s.protect_direction_select ? ~a : a;
		gran = s.protect_granule_select ? (off >> fsr_pkg::SHIFT_4K)
			: (off >> fsr_pkg::SHIFT_64K);
		lim  = (s.protect_range_field == 3'h0) ? 24'h00_0000
			: (24'h00_0001 << (s.protect_range_field - 3'h1));
		return gran < lim;
	endfunction

	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;
	assign cs_rise  = cs_s & ~cs_d_reg;
	assign sel      = ~cs_s;
	assign shift_in = {in_reg[6:0], si_s};
	assign byte_end = sel & sck_rise & (bit_reg == 3'h7);

	// commits happen only at a byte boundary after a whole command
	assign go       = cs_rise & full_reg & (bit_reg == 3'h0);
	assign wren_go  = go & (cmd_reg == fsr_pkg::CMD_WREN);
	assign vwren_go = go & (cmd_reg == fsr_pkg::CMD_VWREN);
	assign wr_go    = go & ((cmd_reg == fsr_pkg::CMD_WRSR)
		| (cmd_reg == fsr_pkg::CMD_IWR));
	assign mem_go   = go & ((cmd_reg == fsr_pkg::CMD_PROG)
		| (cmd_reg == fsr_pkg::CMD_ER4K) | (cmd_reg == fsr_pkg::CMD_ER64K));
	assign locked   = sr1_reg.status_protect_bit_low & ~wp_s;
	assign prot     = prot_hit(addr_reg, sr1_reg);
	assign wr_vol   = wr_go & vwe_reg & ~locked;
	assign wr_nv    = wr_go & ~vwe_reg & sr1_reg.write_enable_latch
		& ~locked;
	assign mem_ok   = mem_go & sr1_reg.write_enable_latch & ~prot;
	assign op_done  = sr1_reg.busy_flag & (cnt_reg == 16'h0001);
	assign enter_rd = byte_end & ((state_reg == fsr_pkg::ST_RDATA)
		| ((state_reg == fsr_pkg::ST_CMD) & (shift_in == fsr_pkg::CMD_RDSR))
		| ((state_reg == fsr_pkg::ST_SEL) & (shift_in == fsr_pkg::SEL_SR1)
		& (cmd_reg == fsr_pkg::CMD_IRD)));

	always_comb begin
		wel_next  = sr1_reg.write_enable_latch;
		busy_next = sr1_reg.busy_flag;
		if (wren_go)
			wel_next = 1'b1;
		else if (op_done)
			wel_next = 1'b0;
		else if ((mem_go & ~mem_ok) | (wr_go & ~vwe_reg & ~wr_nv))
			wel_next = 1'b0;
		if (wr_nv | mem_ok)
			busy_next = 1'b1;
		else if (op_done)
			busy_next = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_d_reg <= 1'b1;
			cs_d_reg  <= 1'b1;
		end else if (ce) begin
			sck_d_reg <= sck_s;
			cs_d_reg  <= cs_s;
		end
	end

	// command byte engine
	always_ff @(posedge clk) begin
		if (sys_rst | dev_rst) begin
			state_reg <= fsr_pkg::ST_CMD;
			bit_reg   <= 3'h0;
			in_reg    <= 8'h00;
			cmd_reg   <= 8'h00;
			wdata_reg <= 8'h00;
			addr_reg  <= 24'h00_0000;
			acnt_reg  <= 2'h0;
			full_reg  <= 1'b0;
		end else if (ce) begin
			if (!sel) begin
				state_reg <= fsr_pkg::ST_CMD;
				acnt_reg  <= 2'h0;
				full_reg  <= 1'b0;
				if (!cs_rise)
					bit_reg <= 3'h0;
			end else if (sck_rise) begin
				bit_reg <= bit_reg + 3'h1;
				in_reg  <= shift_in;
				if (bit_reg == 3'h7) begin
					unique case (state_reg)
					fsr_pkg::ST_CMD: begin
						cmd_reg   <= shift_in;
						state_reg <= fsr_pkg::ST_SKIP;
						if (shift_in == fsr_pkg::CMD_RDSR)
							state_reg <= fsr_pkg::ST_RDATA;
						else if (shift_in == fsr_pkg::CMD_IRD)
							state_reg <= fsr_pkg::ST_SEL;
						else if (!sr1_reg.busy_flag) begin
							if (shift_in == fsr_pkg::CMD_IWR)
								state_reg <= fsr_pkg::ST_SEL;
							else if (shift_in == fsr_pkg::CMD_WRSR)
								state_reg <= fsr_pkg::ST_WDATA;
							else if ((shift_in == fsr_pkg::CMD_PROG)
								| (shift_in == fsr_pkg::CMD_ER4K)
								| (shift_in == fsr_pkg::CMD_ER64K))
								state_reg <= fsr_pkg::ST_ADDR;
							else if ((shift_in == fsr_pkg::CMD_WREN)
								| (shift_in == fsr_pkg::CMD_VWREN))
								full_reg <= 1'b1;
						end
					end
					fsr_pkg::ST_SEL: begin
						if (shift_in != fsr_pkg::SEL_SR1)
							state_reg <= fsr_pkg::ST_SKIP;
						else if (cmd_reg == fsr_pkg::CMD_IRD)
							state_reg <= fsr_pkg::ST_RDATA;
						else
							state_reg <= fsr_pkg::ST_WDATA;
					end
					fsr_pkg::ST_ADDR: begin
						addr_reg <= {addr_reg[15:0], shift_in};
						acnt_reg <= acnt_reg + 2'h1;
						if (acnt_reg == fsr_pkg::ADDR_LAST) begin
							full_reg  <= 1'b1;
							state_reg <= fsr_pkg::ST_SKIP;
						end
					end
					fsr_pkg::ST_WDATA: begin
						wdata_reg <= shift_in;
						full_reg  <= 1'b1;
						state_reg <= fsr_pkg::ST_SKIP;
					end
					fsr_pkg::ST_RDATA, fsr_pkg::ST_SKIP: begin
						state_reg <= state_reg;
					end
					endcase
				end
			end
		end
	end

	// serial output, refreshed from the live register each byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_reg <= 8'h00;
			so_out  <= 1'b0;
			so_oe   <= 1'b0;
		end else if (ce) begin
			if (enter_rd)
				out_reg <= sr1_reg;
			if (!sel) begin
				so_out <= 1'b0;
				so_oe  <= 1'b0;
			end else if (sck_fall && state_reg == fsr_pkg::ST_RDATA) begin
				so_oe  <= 1'b1;
				so_out <= out_reg[3'h7 - bit_reg];
			end
		end
	end

	// write enable source and operation timer
	always_ff @(posedge clk) begin
		if (sys_rst | dev_rst) begin
			vwe_reg     <= 1'b0;
			cnt_reg     <= 16'h0000;
			nv_busy_reg <= 1'b0;
			nv_pend_reg <= 8'h00;
		end else if (ce) begin
			if (cs_rise)
				vwe_reg <= vwren_go;
			if (wr_nv | mem_ok) begin
				cnt_reg     <= fsr_pkg::CNT_W'(OP_CYCLES);
				nv_busy_reg <= wr_nv;
				nv_pend_reg <= wdata_reg;
			end else if (sr1_reg.busy_flag) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
		end
	end

	// slow copy survives a device reset, cleared only at power-up
	always_ff @(posedge clk) begin
		if (sys_rst)
			nv_reg <= fsr_pkg::SR1_RESET;
		else if (ce && !dev_rst && op_done && nv_busy_reg)
			nv_reg <= nv_pend_reg;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sr1_reg <= fsr_pkg::SR1_RESET;
		end else if (dev_rst) begin
			sr1_reg <= {nv_reg[7:2], 2'b00};
		end else if (ce) begin
			if (wr_vol | wr_nv)
				sr1_reg[7:2] <= wdata_reg[7:2];
			sr1_reg.write_enable_latch <= wel_next;
			sr1_reg.busy_flag          <= busy_next;
		end
	end

	default clocking cb @(posedge clk iff ce); endclocking
	default disable iff (sys_rst);

	chk_latch_reset: assert property (dev_rst
		|=> !sr1_reg.write_enable_latch)
		else $error("latch not cleared by reset");
	chk_wren_sets: assert property (!dev_rst && wren_go
		|=> sr1_reg.write_enable_latch)
		else $error("write enable did not set latch");
	chk_vwren_no_latch: assert property (!dev_rst && vwren_go
		&& !sr1_reg.write_enable_latch |=> !sr1_reg.write_enable_latch)
		else $error("volatile enable set latch");
	chk_latch_gates_write: assert property (!dev_rst && wr_go && !vwe_reg
		&& !sr1_reg.write_enable_latch |=> $stable(sr1_reg[7:2]))
		else $error("status written without latch");
	chk_partial_keeps_latch: assert property (!dev_rst && cs_rise && !go
		&& sr1_reg.write_enable_latch && !sr1_reg.busy_flag
		|=> sr1_reg.write_enable_latch)
		else $error("partial command cleared latch");
	chk_protect_refuse: assert property (!dev_rst && mem_go && prot
		&& !sr1_reg.busy_flag |=> !sr1_reg.busy_flag
		&& !sr1_reg.write_enable_latch)
		else $error("protected region accepted");
	chk_busy_done: assert property (!dev_rst && op_done
		|=> !sr1_reg.busy_flag && !sr1_reg.write_enable_latch)
		else $error("operation end did not clear flags");
	chk_read_fresh: assert property (!dev_rst && enter_rd
		|=> out_reg == $past(sr1_reg))
		else $error("stale status byte loaded");
	chk_volatile_fast: assert property (!dev_rst && wr_vol
		&& !sr1_reg.busy_flag |=> sr1_reg[7:2] == $past(wdata_reg[7:2])
		&& !sr1_reg.busy_flag)
		else $error("volatile write wrong");
	chk_busy_started: assert property (!dev_rst && mem_ok
		|=> sr1_reg.busy_flag [*3])
		else $error("busy not held");

	cov_wren: cover property (wren_go);
	cov_nv_write: cover property (wr_nv ##[1:1000] op_done);
	cov_refused: cover property (mem_go && prot);
	cov_poll: cover property (enter_rd && sr1_reg.busy_flag);
endmodule

//--- testbench/fsr_host_model.sv
// spi mode 0 host model that frames commands for status register 1
// assumes the device samples si on sck rise and shifts so after sck fall
`timescale 1ns/1ps
module fsr_host_model (
	input  wire logic       clk,
	output logic            sck,
	output logic            cs_n,
	output logic            si,
	input  wire logic       so_out,
	output logic            rd_valid,
	output logic [7:0]      rd_data
);
	localparam int HALF = 6;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// tx is left aligned: nb whole bytes, then xbits loose bits
	task automatic xfer(input logic [31:0] tx, input int nb, input int xbits,
		input int nrd);
		int i;
		int k;
		cs_n <= 1'b0;
		for (i = 0; i < nb * 8 + xbits; i++) begin
			si <= tx[31 - i];
			wait_clk(HALF);
			sck <= 1'b1;
			wait_clk(HALF);
			sck <= 1'b0;
		end
		for (k = 0; k < nrd; k++) begin
			for (i = 7; i >= 0; i--) begin
				si <= ~si;
				wait_clk(HALF);
				rd_data[i] <= so_out;
				sck <= 1'b1;
				wait_clk(HALF);
				sck <= 1'b0;
			end
			rd_valid <= 1'b1;
			wait_clk(1);
			rd_valid <= 1'b0;
		end
		wait_clk(HALF);
		cs_n <= 1'b1;
		si <= ~si;
		wait_clk(8);
	endtask
endmodule

//--- testbench/fsr_status_one_test.sv
// self-checking bench for status register 1 through its serial pins
// assumes the host model frames commands and reports each read byte
`timescale 1ns/1ps
module fsr_status_one_test;
	logic                 clk;
	logic                 sys_rst;
	logic                 dev_rst;
	logic                 wp_n;
	logic                 sck;
	logic                 cs_n;
	logic                 si;
	logic                 so_out;
	logic                 so_oe;
	logic                 ce;
	logic                 rd_valid;
	logic [7:0]           rd_data;
	fsr_pkg::fsr_status_t sr1_reg;
	logic [7:0]           exp_q[$];
	logic [7:0]           lfsr_v;
	int                   num_errors;
	int                   compares;

	fsr_status_one #(.OP_CYCLES(150)) fsr_status_one_i (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .dev_rst(dev_rst),
		.sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
		.so_out(so_out), .so_oe(so_oe), .sr1_reg(sr1_reg));

	fsr_host_model fsr_host_model_i (
		.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
		.rd_valid(rd_valid), .rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmd(input logic [31:0] tx, input int nb);
		fsr_host_model_i.xfer(tx, nb, 0, 0);
	endtask

	task automatic rd(input logic [7:0] e);
		exp_q.push_back(e);
		fsr_host_model_i.xfer(32'h0500_0000, 1, 0, 1);
	endtask

	// compares each read byte with the oldest note
	always @(posedge clk) begin
		logic [7:0] e;
		if (rd_valid) begin
			e = 8'hxx;
			if (exp_q.size() != 0)
				e = exp_q.pop_front();
			compares = compares + 1;
			if (rd_data !== e) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h expected %h",
					$time, rd_data, e);
			end
			compares = compares + 1;
			if (so_oe !== 1'b1) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h expected %h",
					$time, so_oe, 1'b1);
			end
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors = num_errors + 1;
		complete_run();
	end

	initial begin
		int i;
		logic [7:0] d;
		logic [7:0] v;
		num_errors = 0;
		compares = 0;
		lfsr_v = 8'h55;
		sys_rst = 1'b1;
		dev_rst = 1'b0;
		ce = 1'b1;
		wp_n = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		rd(8'h00);
		cmd(32'h5000_0000, 1);
		rd(8'h00);
		cmd(32'h0600_0000, 1);
		rd(8'h02);
		fsr_host_model_i.xfer(32'h0100_0000, 1, 3, 0);
		cmd(32'hab00_0000, 1);
		cmd(32'h0200_0000, 2);
		rd(8'h02);
		for (i = 0; i < 3; i++) begin
			lfsr_v = lfsr_next(lfsr_v);
			d = lfsr_v & 8'h7f;
			cmd(32'h0600_0000, 1);
			cmd({8'h01, d, 16'h0000}, 2);
			exp_q.push_back({d[7:2], 2'b11});
			exp_q.push_back({d[7:2], 2'b00});
			fsr_host_model_i.xfer(32'h0500_0000, 1, 0, 2);
		end
		cmd({8'h01, ~d, 16'h0000}, 2);
		rd({d[7:2], 2'b00});
		lfsr_v = lfsr_next(lfsr_v);
		v = lfsr_v & 8'h7f;
		cmd(32'h5000_0000, 1);
		cmd({8'h71, 8'h01, v, 8'h00}, 3);
		repeat (200) @(posedge clk);
		exp_q.push_back({v[7:2], 2'b00});
		fsr_host_model_i.xfer(32'h6501_0000, 2, 0, 1);
		dev_rst <= 1'b1;
		@(posedge clk);
		dev_rst <= 1'b0;
		rd({d[7:2], 2'b00});
		cmd(32'h0600_0000, 1);
		cmd(32'h0104_0000, 2);
		repeat (200) @(posedge clk);
		cmd(32'h0600_0000, 1);
		cmd(32'h0200_0010, 4);
		rd(8'h04);
		cmd(32'h0600_0000, 1);
		cmd(32'h0210_0000, 4);
		ce <= 1'b0;
		repeat (300) @(posedge clk);
		compares = compares + 1;
		if (sr1_reg !== 8'h07) begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h expected %h",
				$time, sr1_reg, 8'h07);
		end
		ce <= 1'b1;
		rd(8'h07);
		repeat (200) @(posedge clk);
		rd(8'h04);
		cmd(32'h0600_0000, 1);
		cmd(32'h0164_0000, 2);
		repeat (200) @(posedge clk);
		cmd(32'h0600_0000, 1);
		cmd(32'h20ff_f800, 4);
		rd(8'h64);
		cmd(32'h0600_0000, 1);
		cmd(32'hd800_0000, 4);
		rd(8'h67);
		repeat (200) @(posedge clk);
		cmd(32'h0600_0000, 1);
		cmd(32'h0180_0000, 2);
		repeat (200) @(posedge clk);
		wp_n <= 1'b0;
		cmd(32'h0600_0000, 1);
		cmd(32'h0100_0000, 2);
		repeat (200) @(posedge clk);
		rd(8'h80);
		wp_n <= 1'b1;
		repeat (10) @(posedge clk);
		compares = compares + 1;
		if (sr1_reg !== 8'h80) begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h expected %h",
				$time, sr1_reg, 8'h80);
		end
		complete_run();
	end
endmodule
